// ===== include/ssf_pkg.sv
/*
 Package for the serial status flag block: register map, bit positions,
 reset values and shared structs.
 Assumes a single 100 MHz clock domain and an AHB-Lite register bus.
*/
`default_nettype none
package ssf_pkg;
   localparam logic [7:0] SSF_STATUS_OFS = 8'h00;
   localparam logic [7:0] SSF_IRQ_STATUS_OFS = 8'h04;
   localparam logic [7:0] SSF_IRQ_MASK_OFS = 8'h08;
   localparam int SSF_TXE_BIT = 7;
   localparam int SSF_RXF_BIT = 6;
   localparam int SSF_ORE_BIT = 5;
   localparam int SSF_FRE_BIT = 4;
   localparam int SSF_PRE_BIT = 3;
   localparam int SSF_TXC_BIT = 2;
   localparam int SSF_MPR_BIT = 1;
   localparam int SSF_MPT_BIT = 0;
   localparam logic [7:0] SSF_STATUS_RST = 8'h84;
   localparam logic [7:0] SSF_CLEARABLE = 8'hF8;
   localparam logic [7:0] SSF_IRQ_RST = 8'h00;
   localparam logic [7:0] SSF_MASK_RST = 8'h00;
   localparam logic [1:0] SSF_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] SSF_HSIZE_WORD = 3'h2;

   // Events from the serial datapaths and DMA side, each a one-cycle pulse
   typedef struct packed {
      logic txLoad;
      logic txLastBit;
      logic rxDone;
      logic rxFrameErr;
      logic rxParityErr;
      logic rxMpBit;
      logic dmaTxWrite;
      logic dmaRxRead;
   } ssf_events_s;

   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
      logic hready;
   } ssf_ahb_req_s;
endpackage
`default_nettype wire

// ===== hw/ssf_ahb_slave.sv
/*
 AHB-Lite slave front end: latches the address phase and gives one-cycle
 read and write strobes in the data phase.
 Assumes single word transfers, zero wait states and OKAY only.
*/
`timescale 1ns/1ns
`default_nettype none
module ssf_ahb_slave
   import ssf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   input wire ssf_pkg::ssf_ahb_req_s req,
   output logic hreadyout,
   output logic hresp,
   output logic wrStb,
   output logic rdStb,
   output logic [7:0] regAddr
);
   logic phaseValid_q;
   logic phaseWrite_q;
   logic [7:0] addr_q;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         phaseValid_q <= 1'b0;
         phaseWrite_q <= 1'b0;
         addr_q <= 8'h00;
      end
      else if (clkEn && req.hready)
      begin
         phaseValid_q <= req.hsel && (req.htrans == SSF_HTRANS_NONSEQ);
         phaseWrite_q <= req.hwrite;
         addr_q <= req.haddr[7:0];
      end
   end

   // Zero wait states, so the data phase always ends in one cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wrStb = clkEn && phaseValid_q && phaseWrite_q;
   assign rdStb = clkEn && phaseValid_q && !phaseWrite_q;
   assign regAddr = addr_q;
endmodule
`default_nettype wire

// ===== hw/ssf_irq.sv
/*
 Sticky interrupt status with mask; a read of the status clears it.
 Assumes event pulses from the flag logic and strobes from the bus slave.
*/
`timescale 1ns/1ns
`default_nettype none
module ssf_irq
   import ssf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [7:0] events,
   input wire logic statusRead,
   input wire logic maskWrite,
   input wire logic [7:0] maskData,
   output logic [7:0] irqStatus,
   output logic [7:0] irqMask,
   output logic irq
);
   logic [7:0] status_q;
   logic [7:0] mask_q;

   // A new event in the read cycle survives the clear
   always_ff @(posedge clock)
   begin
      if (rst)
         status_q <= SSF_IRQ_RST;
      else if (clkEn)
         status_q <= (statusRead ? 8'h00 : status_q) | events;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         mask_q <= SSF_MASK_RST;
      else if (clkEn && maskWrite)
         mask_q <= maskData;
   end

   assign irqStatus = status_q;
   assign irqMask = mask_q;
   assign irq = |(status_q & mask_q);
endmodule
`default_nettype wire

// ===== hw/serial_status_flags.sv
/*
 Status flag register of a serial interface with AHB-Lite access,
 read-then-write-zero clearing, DMA side clears and interrupt output.
 Assumes event pulses synchronous to clock from the serial datapaths and DMA side.
*/
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
//////////////////////////////////////////////////////////////////////////
// Function
// [RQ1] Writing one to clearable flags is ignored
// [RQ2] Zero write clears only flags read set
// [RQ3] Complete and received multiproc bits read-only
// [RQ4] Reset and standby force status to 84
// [RQ5] Bit 7 set on holding-to-shift load
// [RQ6] Read one then write zero clears bit 7
// [RQ7] DMA write to holding reg clears bit 7
// [RQ8] Transmitter disable sets bit 7
// [RQ9] Bit 6 set on error-free reception
// [RQ10] Read one then write zero clears bit 6
// [RQ11] DMA read of holding reg clears bit 6
// [RQ12] Errors, receiver disable keep bit 6, data
// [RQ13] Reception while full flags overrun, drops data
// [RQ14] Bit 5 is the overrun error flag
// [RQ15] Bit 4 is the framing error flag
// [RQ16] Bit 3 is the parity error flag
// [RQ17] Complete flag set when last bit, empty
// [RQ18] Per-flag read record, dropped after write
// [RQ19] Hardware set beats software clear
`timescale 1ns/1ns
`default_nettype none
module serial_status_flags
   import ssf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic standby,
   input wire logic transmitterEnable,
   input wire logic receiverEnable,
   input wire ssf_pkg::ssf_events_s ev,
   input wire logic [7:0] rxShiftData,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic [7:0] rxHoldingReg,
   output logic multiprocTxBit,
   output logic irq
);
   //////////////////////////////////////////////////////////////////////
   logic wrStb;
   logic rdStb;
   logic [7:0] regAddr;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic [7:0] seenSet_q;
   logic [7:0] rxHold_q;
   logic [31:0] rdata_q;
   logic [7:0] irqStatus;
   logic [7:0] irqMask;
   logic [7:0] irqEvents;
   logic statusWr;
   logic statusRd;
   logic [7:0] swClear;
   logic rxGood;
   logic rxOverrun;
   logic txeNow;
   logic rxfNow;
   ssf_ahb_req_s req;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign req = '{haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: hsize,
                  hsel: hsel, hready: hready};

   ssf_ahb_slave u_bus (
      .clock(clock),
      .rst(rst),
      .clkEn(clkEn),
      .req(req),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wrStb(wrStb),
      .rdStb(rdStb),
      .regAddr(regAddr)
   );

   assign statusWr = wrStb && hit(regAddr, SSF_STATUS_OFS);
   assign statusRd = rdStb && hit(regAddr, SSF_STATUS_OFS);

   //////////////////////////////////////////////////////////////////////
   // Only zero bits of a write clear, and only where a read saw a one
   assign swClear = statusWr ? (~hwdata[7:0] & seenSet_q & SSF_CLEARABLE)
                             : 8'h00; // [RQ1] [RQ2]

   // Overrun blocks new reception: data and full flag stay put
   assign rxOverrun = ev.rxDone && status_q[SSF_RXF_BIT]; // [RQ13]
   assign rxGood = ev.rxDone && receiverEnable && !status_q[SSF_RXF_BIT]
                   && !ev.rxFrameErr && !ev.rxParityErr; // [RQ9] [RQ12]

   always_comb
   begin
      status_d = status_q;
      // Transmit empty: DMA write and software zero clear, load sets
      if (swClear[SSF_TXE_BIT] || ev.dmaTxWrite)
         status_d[SSF_TXE_BIT] = 1'b0; // [RQ6] [RQ7]
      if (ev.txLoad || !transmitterEnable)
         status_d[SSF_TXE_BIT] = 1'b1; // [RQ5] [RQ8] [RQ19]
      // Transmit complete follows the clears of transmit empty
      if (swClear[SSF_TXE_BIT] || ev.dmaTxWrite)
         status_d[SSF_TXC_BIT] = 1'b0;
      if ((ev.txLastBit && status_q[SSF_TXE_BIT]) || !transmitterEnable)
         status_d[SSF_TXC_BIT] = 1'b1; // [RQ17] [RQ19]
      // Receive full
      if (swClear[SSF_RXF_BIT] || ev.dmaRxRead)
         status_d[SSF_RXF_BIT] = 1'b0; // [RQ10] [RQ11]
      if (rxGood)
         status_d[SSF_RXF_BIT] = 1'b1; // [RQ9] [RQ19]
      // Error flags
      if (swClear[SSF_ORE_BIT])
         status_d[SSF_ORE_BIT] = 1'b0;
      if (rxOverrun && receiverEnable)
         status_d[SSF_ORE_BIT] = 1'b1; // [RQ13] [RQ14] [RQ19]
      if (swClear[SSF_FRE_BIT])
         status_d[SSF_FRE_BIT] = 1'b0;
      if (ev.rxDone && receiverEnable && !rxOverrun && ev.rxFrameErr)
         status_d[SSF_FRE_BIT] = 1'b1; // [RQ15] [RQ19]
      if (swClear[SSF_PRE_BIT])
         status_d[SSF_PRE_BIT] = 1'b0;
      if (ev.rxDone && receiverEnable && !rxOverrun && ev.rxParityErr)
         status_d[SSF_PRE_BIT] = 1'b1; // [RQ16] [RQ19]
      // Received multiproc bit is updated by hardware only
      if (rxGood)
         status_d[SSF_MPR_BIT] = ev.rxMpBit; // [RQ3]
      // Transmitted multiproc bit is plain read/write
      if (statusWr)
         status_d[SSF_MPT_BIT] = hwdata[SSF_MPT_BIT];
   end

   always_ff @(posedge clock)
   begin
      if (rst || standby)
         status_q <= SSF_STATUS_RST; // [RQ4]
      else if (clkEn)
         status_q <= status_d;
   end

   // Read record per flag; any status write consumes it
   always_ff @(posedge clock)
   begin
      if (rst || standby)
         seenSet_q <= 8'h00;
      else if (clkEn)
      begin
         if (statusWr)
            seenSet_q <= 8'h00; // [RQ18]
         else if (statusRd)
            seenSet_q <= seenSet_q | (status_q & SSF_CLEARABLE); // [RQ2] [RQ18]
      end
   end

   // Only a clean reception moves data in; an errored or overrun byte never replaces good data
   always_ff @(posedge clock)
   begin
      if (rst || standby)
         rxHold_q <= 8'h00;
      else if (clkEn && rxGood)
         rxHold_q <= rxShiftData; // [RQ9] [RQ12] [RQ13]
   end

   //////////////////////////////////////////////////////////////////////
   assign txeNow = status_d[SSF_TXE_BIT] && !status_q[SSF_TXE_BIT];
   assign rxfNow = status_d[SSF_RXF_BIT] && !status_q[SSF_RXF_BIT];
   assign irqEvents = {txeNow, rxfNow,
                       status_d[SSF_ORE_BIT] && !status_q[SSF_ORE_BIT],
                       status_d[SSF_FRE_BIT] && !status_q[SSF_FRE_BIT],
                       status_d[SSF_PRE_BIT] && !status_q[SSF_PRE_BIT],
                       status_d[SSF_TXC_BIT] && !status_q[SSF_TXC_BIT],
                       2'b00};

   ssf_irq u_irq (
      .clock(clock),
      .rst(rst || standby),
      .clkEn(clkEn),
      .events(irqEvents),
      .statusRead(rdStb && hit(regAddr, SSF_IRQ_STATUS_OFS)),
      .maskWrite(wrStb && hit(regAddr, SSF_IRQ_MASK_OFS)),
      .maskData(hwdata[7:0]),
      .irqStatus(irqStatus),
      .irqMask(irqMask),
      .irq(irq)
   );

   // Read data registered at address phase so it stands in the data phase
   always_ff @(posedge clock)
   begin
      if (rst)
         rdata_q <= 32'h0000_0000;
      else if (clkEn && hready && hsel && !hwrite && htrans == SSF_HTRANS_NONSEQ)
      begin
         if (hit(haddr[7:0], SSF_STATUS_OFS))
            rdata_q <= {24'h000000, status_d};
         else if (hit(haddr[7:0], SSF_IRQ_STATUS_OFS))
            rdata_q <= {24'h000000, irqStatus | irqEvents};
         else if (hit(haddr[7:0], SSF_IRQ_MASK_OFS))
            rdata_q <= {24'h000000, irqMask};
         else
            rdata_q <= 32'h0000_0000;
      end
   end

   assign hrdata = rdata_q;
   assign rxHoldingReg = rxHold_q;
   assign multiprocTxBit = status_q[SSF_MPT_BIT];

   //////////////////////////////////////////////////////////////////////
   a_write_one_ignored: assert property (@(posedge clock) disable iff (rst)
      (clkEn && !standby && statusWr && hwdata[SSF_RXF_BIT] && !status_q[SSF_RXF_BIT]
       && !rxGood) |=> !status_q[SSF_RXF_BIT]) // [RQ1]
      else $error("write of one set receive full");
   a_clear_needs_read: assert property (@(posedge clock) disable iff (rst)
      (clkEn && !standby && statusWr && !seenSet_q[SSF_ORE_BIT] && status_q[SSF_ORE_BIT])
      |=> status_q[SSF_ORE_BIT]) // [RQ2]
      else $error("overrun cleared without prior read");
   a_complete_readonly: assert property (@(posedge clock) disable iff (rst)
      (clkEn && !standby && statusWr && !swClear[SSF_TXE_BIT] && !ev.dmaTxWrite)
      |=> $stable(status_q[SSF_TXC_BIT]) || status_q[SSF_TXC_BIT]) // [RQ3]
      else $error("write changed transmit complete");
   a_standby_value: assert property (@(posedge clock)
      (rst || standby) |=> status_q == SSF_STATUS_RST) // [RQ4]
      else $error("status not 84 after reset or standby");
   a_load_sets_empty: assert property (@(posedge clock) disable iff (rst)
      (clkEn && !standby && ev.txLoad) |=> status_q[SSF_TXE_BIT]) // [RQ5]
      else $error("load did not set transmit empty");
   a_dma_clears_empty: assert property (@(posedge clock) disable iff (rst)
      (clkEn && !standby && ev.dmaTxWrite && !ev.txLoad && transmitterEnable)
      |=> !status_q[SSF_TXE_BIT]) // [RQ7]
      else $error("dma write did not clear transmit empty");
   a_disable_sets_empty: assert property (@(posedge clock) disable iff (rst)
      (clkEn && !transmitterEnable) |=> status_q[SSF_TXE_BIT] && status_q[SSF_TXC_BIT]) // [RQ8]
      else $error("transmitter disable did not set flags");
   a_overrun_keeps: assert property (@(posedge clock) disable iff (rst)
      (clkEn && !standby && receiverEnable && rxOverrun)
      |=> status_q[SSF_ORE_BIT] && $stable(rxHold_q)) // [RQ13]
      else $error("overrun not flagged or data overwritten");
   a_dma_read_clears: assert property (@(posedge clock) disable iff (rst)
      (clkEn && !standby && ev.dmaRxRead && !rxGood) |=> !status_q[SSF_RXF_BIT]) // [RQ11]
      else $error("dma read did not clear receive full");
   a_error_keeps_data: assert property (@(posedge clock) disable iff (rst)
      (clkEn && !standby && ev.rxDone && (ev.rxFrameErr || ev.rxParityErr))
      |=> $stable(rxHold_q) && !$rose(status_q[SSF_RXF_BIT])) // [RQ12]
      else $error("receive error changed holding data or full flag");
endmodule
`default_nettype wire

// ===== dv/ssf_event_source.sv
/*
 Model of the serial datapaths and DMA side that feed the status flags:
 gives one-cycle event pulses with receive data beside them.
 Assumes the testbench calls pulse from its own clocked sequence.
*/
`timescale 1ns/1ns
`default_nettype none
module ssf_event_source
   import ssf_pkg::*;
(
   input wire logic clock,
   output ssf_pkg::ssf_events_s ev,
   output logic [7:0] rxShiftData
);
   import ssf_pkg::*;
   //////////////////////////////////////////////////////////////////////
   initial
   begin
      ev = '0;
      rxShiftData = 8'h00;
   end
   // Data flips once the pulse is over, so a stale byte never looks valid
   task automatic pulse(input ssf_events_s e, input logic [7:0] d);
      @(posedge clock);
      ev <= e;
      rxShiftData <= d;
      @(posedge clock);
      ev <= '0;
      rxShiftData <= ~d;
   endtask
endmodule
`default_nettype wire

// ===== dv/serial_status_flags_tb_top.sv
/*
 Self-checking testbench of the serial status flags over AHB-Lite.
 Assumes the event source model beside it and a single 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_status_flags_tb_top;
   import ssf_pkg::*;
   logic clock, rst, clkEn, standby, transmitterEnable, receiverEnable;
   ssf_events_s ev;
   logic [7:0] rxShiftData, rxHoldingReg;
   logic hsel, hwrite, hreadyout, hresp, multiprocTxBit, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int failures, checked;
   //////////////////////////////////////////////////////////////////////
   serial_status_flags u_dut (.clock(clock), .rst(rst), .clkEn(clkEn), .standby(standby),
      .transmitterEnable(transmitterEnable), .receiverEnable(receiverEnable), .ev(ev),
      .rxShiftData(rxShiftData), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxHoldingReg(rxHoldingReg),
      .multiprocTxBit(multiprocTxBit), .irq(irq));
   ssf_event_source u_src (.clock(clock), .ev(ev), .rxShiftData(rxShiftData));
   //////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Master waits on hready without assuming a latency; only the watchdog ends a wait
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= SSF_HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= w;
      hsize <= SSF_HSIZE_WORD;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] d;
      bus(1'b0, a, 32'h00000000, d);
      chk(d, {24'h000000, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, a, {24'h000000, d}, x);
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      rdchk(SSF_STATUS_OFS, 8'h84);
      chk({31'h0, hresp}, 32'h0);
      rdchk(SSF_IRQ_MASK_OFS, 8'h00);
      wr(SSF_STATUS_OFS, 8'hFF);
      rdchk(SSF_STATUS_OFS, 8'h85);
      chk({31'h0, multiprocTxBit}, 32'h1);
      // Ones only spend the read record, so the zero write after them clears only the transmitted multiproc bit
      wr(SSF_STATUS_OFS, 8'hFF);
      wr(SSF_STATUS_OFS, 8'h00);
      rdchk(SSF_STATUS_OFS, 8'h84);
      chk({31'h0, multiprocTxBit}, 32'h0);
   endtask
   task automatic test_tx;
      wr(SSF_STATUS_OFS, 8'h00);
      rdchk(SSF_STATUS_OFS, 8'h00);
      u_src.pulse(8'h80, 8'h00);
      rdchk(SSF_STATUS_OFS, 8'h80);
      u_src.pulse(8'h40, 8'h00);
      rdchk(SSF_STATUS_OFS, 8'h84);
      u_src.pulse(8'h02, 8'h00);
      rdchk(SSF_STATUS_OFS, 8'h00);
      @(posedge clock);
      transmitterEnable <= 1'b0;
      @(posedge clock);
      transmitterEnable <= 1'b1;
      rdchk(SSF_STATUS_OFS, 8'h84);
      // Writing one keeps the flag and drops the pending read record
      wr(SSF_STATUS_OFS, 8'h80);
      rdchk(SSF_STATUS_OFS, 8'h84);
   endtask
   task automatic test_rx;
      u_src.pulse(8'h24, 8'h5A);
      rdchk(SSF_STATUS_OFS, 8'hC6);
      chk({24'h0, rxHoldingReg}, 32'h5A);
      u_src.pulse(8'h20, 8'hA5);
      // Overrun was never read set, so this zero in its bit must not clear it
      wr(SSF_STATUS_OFS, 8'hC0);
      rdchk(SSF_STATUS_OFS, 8'hE6);
      chk({24'h0, rxHoldingReg}, 32'h5A);
      u_src.pulse(8'h01, 8'h00);
      rdchk(SSF_STATUS_OFS, 8'hA6);
      wr(SSF_STATUS_OFS, 8'h80);
      rdchk(SSF_STATUS_OFS, 8'h86);
      u_src.pulse(8'h30, 8'h3C);
      rdchk(SSF_STATUS_OFS, 8'h96);
      chk({24'h0, rxHoldingReg}, 32'h5A);
      u_src.pulse(8'h28, 8'h3D);
      rdchk(SSF_STATUS_OFS, 8'h9E);
      wr(SSF_STATUS_OFS, 8'h80);
      @(posedge clock);
      receiverEnable <= 1'b0;
      u_src.pulse(8'h24, 8'h77);
      receiverEnable <= 1'b1;
      rdchk(SSF_STATUS_OFS, 8'h86);
      u_src.pulse(8'h20, 8'h11);
      rdchk(SSF_STATUS_OFS, 8'hC4);
      chk({24'h0, rxHoldingReg}, 32'h11);
      wr(SSF_STATUS_OFS, 8'h80);
      rdchk(SSF_STATUS_OFS, 8'h84);
   endtask
   task automatic test_irq;
      logic [31:0] x;
      bus(1'b0, SSF_IRQ_STATUS_OFS, 32'h0, x);
      wr(SSF_IRQ_MASK_OFS, 8'h40);
      rdchk(SSF_IRQ_MASK_OFS, 8'h40);
      u_src.pulse(8'h20, 8'h22);
      @(negedge clock);
      chk({31'h0, irq}, 32'h1);
      rdchk(SSF_IRQ_STATUS_OFS, 8'h40);
      @(negedge clock);
      chk({31'h0, irq}, 32'h0);
      wr(SSF_IRQ_MASK_OFS, 8'h00);
      u_src.pulse(8'h01, 8'h00);
      u_src.pulse(8'h20, 8'h23);
      @(negedge clock);
      chk({31'h0, irq}, 32'h0);
      rdchk(SSF_IRQ_STATUS_OFS, 8'h40);
   endtask
   task automatic test_standby;
      // A DMA read while the clock enable is low must leave receive full set
      @(posedge clock);
      clkEn <= 1'b0;
      u_src.pulse(8'h01, 8'h00);
      clkEn <= 1'b1;
      rdchk(SSF_STATUS_OFS, 8'hC4);
      @(posedge clock);
      standby <= 1'b1;
      @(posedge clock);
      standby <= 1'b0;
      rdchk(SSF_STATUS_OFS, 8'h84);
   endtask
   //////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Whole run is under two hundred cycles; the limit of ten thousand leaves wide margin
   initial
   begin
      #100000;
      failures++;
      close_out();
   end
   initial
   begin
      failures = 0;
      checked = 0;
      rst = 1'b1;
      clkEn = 1'b1;
      standby = 1'b0;
      transmitterEnable = 1'b1;
      receiverEnable = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h00000000;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      test_reset();
      test_tx();
      test_rx();
      test_irq();
      test_standby();
      close_out();
   end
endmodule
`default_nettype wire
